// ==== rtl/tmc_map.svh ====
// Purpose: offsets, field positions and reset values of the texture block
// Assumes: byte addresses on a 12-bit AXI4-Lite address
// Notes:   definitions only
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TMC_CTRL_OFF   12'h000
`define TMC_STAT_OFF   12'h004

// ---------------------------------------------------------------
// texture_control fields
// ---------------------------------------------------------------
`define TMC_PERSP_BIT  0
`define TMC_MINF_BIT   1
`define TMC_MAGF_BIT   2
`define TMC_CLAMPW_BIT 3
`define TMC_DITH_BIT   4
`define TMC_NCC_BIT    5
`define TMC_CLAMPS_BIT 6
`define TMC_CLAMPT_BIT 7
`define TMC_FMT_LSB    8
`define TMC_COLOR_LSB  12
`define TMC_ALPHA_LSB  21
`define TMC_TRI_BIT    30
`define TMC_CTRL_RST   32'h0000_0000
`define TMC_CTRL_WMASK 32'h7FFF_FFFF

// ---------------------------------------------------------------
// combine control layout inside a 9-bit group
// ---------------------------------------------------------------
`define TMC_CB_ZERO    0
`define TMC_CB_SUB     1
`define TMC_CB_MUX     2
`define TMC_CB_REV     5
`define TMC_CB_ADDC    6
`define TMC_CB_ADDA    7
`define TMC_CB_INV     8

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define TMC_RESP_OKAY  2'h0
`define TMC_RESP_SLV   2'h2

`endif

// ==== rtl/tmc_pkg.sv ====
// Purpose: types of the texture control block
// Assumes: nothing
// Notes:   numbers live in tmc_map.svh
package tmc_pkg;
  typedef enum logic [2:0] {
    TMC_F_ZERO, TMC_F_LOCAL, TMC_F_AOTHER, TMC_F_ALOCAL,
    TMC_F_LOD, TMC_F_LODFRAC, TMC_F_RSV6, TMC_F_RSV7
  } tmc_factor_t;
  typedef logic [8:0] tmc_cb_ctl_t;
endpackage

// ==== rtl/tmc_texture_control.sv ====
// Purpose: texture_control register, AXI4-Lite slave, texel address,
//          filter choice and four texture combine units
// Assumes: pixel inputs come from logic on ref_clk_i
// Notes:   results are valid one cycle after px_valid_i
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_texture_control (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        px_valid_i,
  input  wire logic [15:0] px_s_i,
  input  wire logic [15:0] px_t_i,
  input  wire logic [15:0] px_sw_i,
  input  wire logic [15:0] px_tw_i,
  input  wire logic        px_w_neg_i,
  input  wire logic        px_x0_i,
  input  wire logic        px_y0_i,
  input  wire logic [5:0]  lod_i,
  input  wire logic [5:0]  lod_min_i,
  input  wire logic [3:0]  width_log2_i,
  input  wire logic [3:0]  height_log2_i,
  input  wire logic [31:0] c_local_i,
  input  wire logic [31:0] c_other_i,
  output logic             tx_valid_o,
  output logic [11:0]      tx_s0_o,
  output logic [11:0]      tx_s1_o,
  output logic [11:0]      tx_t0_o,
  output logic [11:0]      tx_t1_o,
  output logic [3:0]       tx_frac_s_o,
  output logic [3:0]       tx_frac_t_o,
  output logic             tx_bilinear_o,
  output logic             trilinear_o,
  output logic             ncc_table_o,
  output logic [3:0]       texel_format_o,
  output logic [31:0]      comb_out_o
);

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [7:0]  stat_q;
  logic        wr_go;

  assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `TMC_RESP_OKAY;
      awaddr_q        <= 12'h000;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q        <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q        <= s_axi_wdata_i;
        wstrb_q        <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (awaddr_q == `TMC_CTRL_OFF ||
                           awaddr_q == `TMC_STAT_OFF) ?
                          `TMC_RESP_OKAY : `TMC_RESP_SLV;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `TMC_CTRL_RST;
    end else if (wr_go && awaddr_q == `TMC_CTRL_OFF) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          ctrl_q[8*b +: 8] <= wdata_q[8*b +: 8] &
                              8'(`TMC_CTRL_WMASK >> (8*b));
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `TMC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= `TMC_RESP_OKAY;
      if (s_axi_araddr_i == `TMC_CTRL_OFF) begin
        s_axi_rdata_o <= ctrl_q;
      end else if (s_axi_araddr_i == `TMC_STAT_OFF) begin
        s_axi_rdata_o <= {24'h00_0000, stat_q};
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= `TMC_RESP_SLV;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // static controls
  // ---------------------------------------------------------------
  assign trilinear_o    = ctrl_q[`TMC_TRI_BIT];
  assign ncc_table_o    = ctrl_q[`TMC_NCC_BIT];
  // one format for read expansion and write packing
  assign texel_format_o = ctrl_q[`TMC_FMT_LSB +: 4];

  // ---------------------------------------------------------------
  // coordinate selection, lod and filter choice
  // ---------------------------------------------------------------
  function automatic logic [11:0] fit(input logic signed [12:0] c,
                                      input logic [3:0] lg,
                                      input logic clamp);
    logic signed [12:0] lim;
    lim = 13'sh0001 <<< lg;
    if (clamp) begin
      if (c < 0) begin
        fit = 12'h000;
      end else if (c >= lim) begin
        fit = 12'(lim - 13'sh0001);
      end else begin
        fit = c[11:0];
      end
    end else begin
      fit = 12'(c & (lim - 13'sh0001));
    end
  endfunction

  logic [15:0] s_sel;
  logic [15:0] t_sel;
  logic [1:0]  dith;
  logic [6:0]  lod_d;
  logic        min_sel;
  logic        bil_d;

  always_comb begin
    s_sel = ctrl_q[`TMC_PERSP_BIT] ? px_sw_i : px_s_i;
    t_sel = ctrl_q[`TMC_PERSP_BIT] ? px_tw_i : px_t_i;
    if (ctrl_q[`TMC_CLAMPW_BIT] && px_w_neg_i) begin
      s_sel = 16'h0000;
      t_sel = 16'h0000;
    end
    // quarter steps 0..3 over a 2x2 pattern average 3/8
    dith = ctrl_q[`TMC_DITH_BIT] ?
           {px_x0_i ^ px_y0_i, px_y0_i} : 2'h0;
    lod_d   = {1'b0, lod_i} + {5'h00, dith};
    min_sel = lod_d >= {1'b0, lod_min_i};
    bil_d   = min_sel ? ctrl_q[`TMC_MINF_BIT] :
                        ctrl_q[`TMC_MAGF_BIT];
  end

  // ---------------------------------------------------------------
  // texel addresses
  // ---------------------------------------------------------------
  logic signed [12:0] s_int;
  logic signed [12:0] t_int;

  assign s_int = {s_sel[15], s_sel[15:4]};
  assign t_int = {t_sel[15], t_sel[15:4]};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_valid_o    <= 1'b0;
      tx_s0_o       <= 12'h000;
      tx_s1_o       <= 12'h000;
      tx_t0_o       <= 12'h000;
      tx_t1_o       <= 12'h000;
      tx_frac_s_o   <= 4'h0;
      tx_frac_t_o   <= 4'h0;
      tx_bilinear_o <= 1'b0;
      stat_q        <= 8'h00;
    end else begin
      tx_valid_o <= px_valid_i;
      if (px_valid_i) begin
        tx_s0_o <= fit(s_int, width_log2_i,
                       ctrl_q[`TMC_CLAMPS_BIT]);
        tx_t0_o <= fit(t_int, height_log2_i,
                       ctrl_q[`TMC_CLAMPT_BIT]);
        // point: second texel equals first
        tx_s1_o <= fit(bil_d ? s_int + 13'sh0001 : s_int,
                       width_log2_i, ctrl_q[`TMC_CLAMPS_BIT]);
        tx_t1_o <= fit(bil_d ? t_int + 13'sh0001 : t_int,
                       height_log2_i, ctrl_q[`TMC_CLAMPT_BIT]);
        tx_frac_s_o   <= bil_d ? s_sel[3:0] : 4'h0;
        tx_frac_t_o   <= bil_d ? t_sel[3:0] : 4'h0;
        tx_bilinear_o <= bil_d;
        stat_q <= {bil_d, min_sel, lod_d[5:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // combine units: red, green, blue, then alpha
  // ---------------------------------------------------------------
  logic [7:0] cmb_ch [4];

  for (genvar c = 0; c < 4; c++) begin : g_cmb
    tmc_pkg::tmc_cb_ctl_t ctl;
    assign ctl = (c == 3) ? ctrl_q[`TMC_ALPHA_LSB +: 9] :
                            ctrl_q[`TMC_COLOR_LSB +: 9];
    always_comb begin
      logic [7:0]         loc;
      logic [7:0]         oth;
      logic [7:0]         sub;
      logic [7:0]         f;
      logic signed [9:0]  diff;
      logic signed [19:0] prod;
      logic signed [19:0] sum;
      f    = 8'h00;
      loc  = c_local_i[8*c +: 8];
      oth  = ctl[`TMC_CB_ZERO] ? 8'h00 : c_other_i[8*c +: 8];
      sub  = ctl[`TMC_CB_SUB] ? loc : 8'h00;
      case (tmc_pkg::tmc_factor_t'(ctl[`TMC_CB_MUX +: 3]))
        tmc_pkg::TMC_F_LOCAL:   f = loc;
        tmc_pkg::TMC_F_AOTHER:  f = c_other_i[31:24];
        tmc_pkg::TMC_F_ALOCAL:  f = c_local_i[31:24];
        tmc_pkg::TMC_F_LOD:     f = {lod_i, 2'h0};
        tmc_pkg::TMC_F_LODFRAC: f = {lod_i[1:0], 6'h00};
        default:                f = 8'h00;
      endcase
      if (ctl[`TMC_CB_REV]) begin
        f = ~f;
      end
      diff = $signed({2'h0, oth}) - $signed({2'h0, sub});
      prod = (20'(diff) * $signed({11'h000, f} + 20'sh00001)) >>> 8;
      sum  = prod;
      if (ctl[`TMC_CB_ADDC]) begin
        sum = sum + $signed({12'h000, loc});
      end
      if (ctl[`TMC_CB_ADDA]) begin
        sum = sum + $signed({12'h000, c_local_i[31:24]});
      end
      if (sum < 0) begin
        cmb_ch[c] = 8'h00;
      end else if (sum > 20'sh000FF) begin
        cmb_ch[c] = 8'hFF;
      end else begin
        cmb_ch[c] = sum[7:0];
      end
      if (ctl[`TMC_CB_INV]) begin
        cmb_ch[c] = ~cmb_ch[c];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      comb_out_o <= 32'h0000_0000;
    end else if (px_valid_i) begin
      comb_out_o <= {cmb_ch[3], cmb_ch[2], cmb_ch[1], cmb_ch[0]};
    end
  end

endmodule

// ==== tb/tmc_tc_chk.sv ====
// Purpose: port checker of the texture control block
// Assumes: one clock, reset active high
// Notes:   bound to every tmc_texture_control
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_tc_chk (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        px_valid_i,
  input wire logic        tx_valid_o,
  input wire logic [11:0] tx_s0_o,
  input wire logic [11:0] tx_s1_o,
  input wire logic [3:0]  tx_frac_s_o,
  input wire logic        tx_bilinear_o,
  input wire logic        trilinear_o,
  input wire logic        ncc_table_o,
  input wire logic [3:0]  texel_format_o
);
  logic [31:0] shadow_q;
  logic [31:0] mask;
  logic        wr_take;

  // ------------------------------------------------------------
  // shadow copy of texture_control
  // ------------------------------------------------------------
  assign mask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                 {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  assign wr_take = s_axi_awvalid_i && s_axi_awready_o
                   && s_axi_wvalid_i && s_axi_wready_o;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shadow_q <= `TMC_CTRL_RST;
    end else if (wr_take && s_axi_awaddr_i == `TMC_CTRL_OFF) begin
      shadow_q <= (shadow_q & ~mask) | (s_axi_wdata_i & mask);
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr_take;
    wr_take;
  endsequence
  sequence s_wr_done;
    s_axi_bvalid_o && s_axi_bready_i;
  endsequence

  a_write_answer: assert property (
    s_wr_take |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write answer out of step");
  a_tx_follow: assert property (
    px_valid_i |=> tx_valid_o) else $error("pixel not answered");
  a_tx_quiet: assert property (
    !px_valid_i |=> !tx_valid_o) else $error("spurious pixel result");
  a_point_one: assert property (
    tx_valid_o && !tx_bilinear_o |-> tx_s1_o == tx_s0_o
    && tx_frac_s_o == 4'h0) else $error("point fetch not single");
  a_tri_bit: assert property (
    s_wr_done |=> trilinear_o == shadow_q[30])
    else $error("trilinear output wrong");
  a_ncc_bit: assert property (
    s_wr_done |=> ncc_table_o == shadow_q[5])
    else $error("table select wrong");
  a_fmt_field: assert property (
    s_wr_done |=> texel_format_o == shadow_q[11:8])
    else $error("texel format wrong");
  a_bit31_zero: assert property (
    s_axi_rvalid_o |-> !s_axi_rdata_o[31]) else $error("bit 31 read set");
endmodule

bind tmc_texture_control tmc_tc_chk u_chk (.*);

// ==== tb/tb_tmc_texture_control.sv ====
// Purpose: self-checking bench of the texture control block
// Assumes: AXI4-Lite master tasks, one pixel at a time
// Notes:   expected values worked out by hand below
`timescale 1ns/1ns
`include "tmc_map.svh"
`define CMP(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (a), (e)); end end

module tb_tmc_texture_control;
  logic        ref_clk_i, sys_rst_i, s_axi_awvalid_i, s_axi_awready_o;
  logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i, px_valid_i, px_w_neg_i;
  logic        px_x0_i, px_y0_i, tx_valid_o, tx_bilinear_o;
  logic        trilinear_o, ncc_table_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  logic [3:0]  s_axi_wstrb_i, width_log2_i, height_log2_i, tx_frac_s_o;
  logic [3:0]  tx_frac_t_o, texel_format_o;
  logic [5:0]  lod_i, lod_min_i;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i, tx_s0_o, tx_s1_o;
  logic [11:0] tx_t0_o, tx_t1_o;
  logic [15:0] px_s_i, px_t_i, px_sw_i, px_tw_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, c_local_i, c_other_i;
  logic [31:0] comb_out_o, d;
  int          checked, miscompares;
  localparam logic [31:0] CB_CTL [5] = '{32'h0402_0000, 32'h0824_1000,
    32'h1028_1000, 32'h0442_2000, 32'h2472_3000};
  localparam logic [31:0] CB_EXP [5] = '{32'h8070_6050, 32'h4030_2010,
    32'h4040_4040, 32'h4040_4040, 32'hFFFF_FFFF};

  tmc_texture_control dut (.*);

  // ------------------------------------------------------------
  // bus and pixel tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever begin
      @(posedge ref_clk_i);
      if (aw && s_axi_awready_o) begin
        aw = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (w && s_axi_wready_o) begin
        w = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
      if (s_axi_bvalid_o) begin
        r = s_axi_bresp_o;
        break;
      end
    end
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) begin
        s_axi_arvalid_i <= 1'b0;
      end
      if (s_axi_rvalid_o) begin
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        break;
      end
    end
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic ctl(input logic [31:0] v);
    wr(`TMC_CTRL_OFF, v, 4'hF);
  endtask

  task automatic pix(input logic [15:0] s, input logic [15:0] t,
                     input logic [15:0] sw);
    @(posedge ref_clk_i);
    px_s_i <= s;
    px_t_i <= t;
    px_sw_i <= sw;
    px_tw_i <= sw;
    px_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    px_valid_i <= 1'b0;
    #1;
    `CMP(tx_valid_o, 1'b1)
  endtask

  function automatic logic [31:0] mux_exp(input int k);
    logic [7:0] f;
    case (k)
      1: return c_local_i;
      2: f = 8'hFF;
      3: f = 8'h40;
      4: f = 8'hB4;
      5: f = 8'h40;
      default: f = 8'h00;
    endcase
    return {4{f}};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(`TMC_CTRL_OFF);
    `CMP(d, `TMC_CTRL_RST)
    wr(`TMC_CTRL_OFF, 32'hFFFF_FFFF, 4'hF);
    `CMP(r, `TMC_RESP_OKAY)
    rd(`TMC_CTRL_OFF);
    `CMP({r, d}, {`TMC_RESP_OKAY, 32'h7FFF_FFFF})
    `CMP({trilinear_o, ncc_table_o}, 2'h3)
    `CMP(texel_format_o, 4'hF)
    wr(`TMC_CTRL_OFF, 32'h0, 4'h2);
    rd(`TMC_CTRL_OFF);
    `CMP(d, 32'h7FFF_00FF)
    `CMP(texel_format_o, 4'h0)
    rd(12'h010);
    `CMP({r, d}, {`TMC_RESP_SLV, 32'h0})
    wr(12'h010, 32'hFFFF_FFFF, 4'hF);
    `CMP(r, `TMC_RESP_SLV)
  endtask

  task automatic t_addr;
    ctl(32'h0000_00C0);
    pix(16'hFFF0, 16'h0140, 16'h0);
    `CMP({tx_s0_o, tx_t0_o}, 24'h000_00F)
    `CMP({tx_s1_o, tx_frac_s_o, tx_bilinear_o}, 17'h0)
    ctl(32'h0000_0002);
    @(posedge ref_clk_i);
    lod_i <= 6'h10;
    pix(16'h0125, 16'h0FF7, 16'h0);
    `CMP({tx_s0_o, tx_s1_o, tx_t0_o, tx_t1_o}, 48'h002_003_00F_000)
    `CMP({tx_frac_s_o, tx_frac_t_o}, 8'h57)
    `CMP(tx_bilinear_o, 1'b1)
    ctl(32'h0000_0004);
    pix(16'h0125, 16'h0FF7, 16'h0);
    `CMP(tx_bilinear_o, 1'b0)
    ctl(32'h0000_0009);
    pix(16'h0125, 16'h0FF7, 16'h0035);
    `CMP(tx_s0_o, 12'h003)
    @(posedge ref_clk_i);
    px_w_neg_i <= 1'b1;
    pix(16'h0125, 16'h0FF7, 16'h0035);
    `CMP({tx_s0_o, tx_t0_o, tx_frac_s_o}, 28'h0)
  endtask

  task automatic t_dither;
    ctl(32'h0000_0002);
    @(posedge ref_clk_i);
    {px_w_neg_i, px_x0_i, px_y0_i, lod_i} <= 9'h0CF;
    pix(16'h0, 16'h0, 16'h0);
    `CMP(tx_bilinear_o, 1'b0)
    ctl(32'h0000_0012);
    pix(16'h0, 16'h0, 16'h0);
    `CMP(tx_bilinear_o, 1'b1)
    rd(`TMC_STAT_OFF);
    `CMP({r, d}, {`TMC_RESP_OKAY, 32'h0000_00D0})
    @(posedge ref_clk_i);
    {px_x0_i, px_y0_i} <= 2'h0;
    pix(16'h0, 16'h0, 16'h0);
    `CMP(tx_bilinear_o, 1'b0)
  endtask

  task automatic t_comb;
    @(posedge ref_clk_i);
    lod_i <= 6'h2D;
    for (int k = 0; k < 8; k++) begin
      ctl((32'(k) << 14) | (32'(k) << 23));
      pix(16'h0, 16'h0, 16'h0);
      `CMP(comb_out_o, mux_exp(k))
    end
    @(posedge ref_clk_i);
    c_other_i <= 32'h8070_6050;
    for (int k = 0; k < 5; k++) begin
      ctl(CB_CTL[k]);
      pix(16'h0, 16'h0, 16'h0);
      `CMP(comb_out_o, CB_EXP[k])
    end
  endtask

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares++;
    results();
  end

  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
    {s_axi_rready_i, px_valid_i, px_w_neg_i, px_x0_i, px_y0_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
    {px_s_i, px_t_i, px_sw_i, px_tw_i, lod_i} = '0;
    {width_log2_i, height_log2_i, lod_min_i} = 14'h1110;
    c_local_i = 32'h4030_2010;
    c_other_i = 32'hFFFF_FFFF;
    checked = 0;
    miscompares = 0;
    sys_rst_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_addr();
    t_dither();
    t_comb();
    results();
  end
endmodule
